/* hdl/i2c_cond_detect.sv */
// Start and stop condition detector on synchronised bus lines.
`timescale 1ns/100ps
module i2c_cond_detect (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Detected conditions
  output logic      start_o,
  output logic      stop_o
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       sda_prev;
  logic       scl_prev;
  logic [1:0] next_scl_sync;
  logic [1:0] next_sda_sync;

  always_comb begin
    next_scl_sync = {scl_sync[0], scl_i};
    next_sda_sync = {sda_sync[0], sda_i};
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      sda_prev <= sda_sync[1];
      scl_prev <= scl_sync[1];
    end
  end

  // A start is SDA falling while SCL stays high; a stop is SDA rising.
  assign start_o = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign stop_o  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
endmodule

/* hdl/i2c_flags_defines.svh */
// Register offsets, field positions and reset values of the serial port status flags.
// Function
// RULE_01 - Transmit: buffer full until shift completes
// RULE_02 - Receive: byte load sets, read clears
// RULE_03 - Direction captured at match, valid until condition
// RULE_04 - Stop/start flags cleared on reset, disable
// RULE_05 - Active equals direction OR sequence enables
// RULE_06 - 10-bit mode raises update-address request
// RULE_07 - Stop/start flags show last condition
`ifndef I2C_FLAGS_DEFINES_SVH
`define I2C_FLAGS_DEFINES_SVH
`define STATUS_ADDR      4'h0
`define CONTROL_ADDR     4'h1
`define BIT_BUF_FULL     0
`define BIT_UPDATE_ADDR  1
`define BIT_DIRECTION    2
`define BIT_START        3
`define BIT_STOP         4
`define BIT_SLEW_CTRL    7
`define BIT_LEVEL_SEL    6
`define BIT_DATA_ADDR    5
`define CTL_PORT_EN      0
`define CTL_TEN_BIT      1
`define CTL_START_EN     2
`define CTL_RSTART_EN    3
`define CTL_STOP_EN      4
`define CTL_RECV_EN      5
`define CTL_ACK_EN       6
`define CTL_RESET_VALUE  16'h0000
`define STATUS_WIDTH     16
`endif

/* hdl/i2c_flags_pkg.sv */
// Types shared by the serial port status flag logic.
package i2c_flags_pkg;
  typedef enum logic [1:0] {
    DIR_IDLE  = 2'b00,
    DIR_VALID = 2'b01
  } dir_state_t;
endpackage

/* hdl/i2c_port_status_flags.sv */
// Status flag logic of the serial port in I2C mode.
`timescale 1ns/100ps
`include "i2c_flags_defines.svh"
module i2c_port_status_flags (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  // Shift engine events
  input  wire logic        tx_load_i,
  input  wire logic        tx_done_i,
  input  wire logic        rx_byte_i,
  input  wire logic        buf_read_i,
  input  wire logic        addr_match_i,
  input  wire logic        addr_rw_i,
  input  wire logic        nack_i,
  input  wire logic        addr_high_done_i,
  input  wire logic        slave_addr_wr_i,
  // Flag outputs
  output logic             buffer_full_flag_o,
  output logic             port_active_o
);
  logic        start_det;
  logic        stop_det;
  logic [15:0] ctrl;
  logic        buf_full;
  logic        update_addr;
  logic        direction;
  logic        start_flag;
  logic        stop_flag;
  logic [15:0] rdata;
  logic        active;
  i2c_flags_pkg::dir_state_t dir_state;
  logic [15:0] next_ctrl;
  logic        next_buf_full;
  logic        next_update_addr;
  logic        next_direction;
  logic        next_start_flag;
  logic        next_stop_flag;
  logic [15:0] next_rdata;
  logic        next_active;
  i2c_flags_pkg::dir_state_t next_dir_state;
  logic [15:0] status_word;
  logic        port_en;

  i2c_cond_detect u_detect (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .start_o   (start_det),
    .stop_o    (stop_det)
  );

  assign port_en = ctrl[`CTL_PORT_EN];

  // ==========================================================================
  // Flag next state
  always_comb begin
    next_ctrl = ctrl;
    if (reg_wr_i && reg_addr_i == `CONTROL_ADDR) begin
      next_ctrl = reg_wdata_i;
    end
    // RULE_01 RULE_02 buffer full tracking
    next_buf_full = buf_full;
    if (tx_done_i || buf_read_i) begin
      next_buf_full = 1'b0;
    end
    if (tx_load_i || rx_byte_i) begin
      next_buf_full = 1'b1;
    end
    // RULE_06 update-address request
    next_update_addr = update_addr;
    if (slave_addr_wr_i) begin
      next_update_addr = 1'b0;
    end
    if (ctrl[`CTL_TEN_BIT] && (addr_high_done_i || addr_match_i)) begin
      next_update_addr = 1'b1;
    end
    // RULE_03 direction capture and validity window
    next_direction = direction;
    next_dir_state = dir_state;
    unique case (dir_state)
      i2c_flags_pkg::DIR_IDLE: begin
        if (addr_match_i) begin
          next_direction = addr_rw_i;
          next_dir_state = i2c_flags_pkg::DIR_VALID;
        end
      end
      i2c_flags_pkg::DIR_VALID: begin
        if (start_det || stop_det || nack_i) begin
          next_direction = 1'b0;
          next_dir_state = i2c_flags_pkg::DIR_IDLE;
        end else if (addr_match_i) begin
          next_direction = addr_rw_i;
        end
      end
      default: begin
        next_direction = 1'b0;
        next_dir_state = i2c_flags_pkg::DIR_IDLE;
      end
    endcase
    // RULE_07 last condition wins
    next_start_flag = start_flag;
    next_stop_flag  = stop_flag;
    if (start_det) begin
      next_start_flag = 1'b1;
      next_stop_flag  = 1'b0;
    end else if (stop_det) begin
      next_start_flag = 1'b0;
      next_stop_flag  = 1'b1;
    end
    // RULE_04 cleared while disabled
    if (!next_ctrl[`CTL_PORT_EN]) begin
      next_start_flag  = 1'b0;
      next_stop_flag   = 1'b0;
      next_buf_full    = 1'b0;
      next_update_addr = 1'b0;
      next_direction   = 1'b0;
      next_dir_state   = i2c_flags_pkg::DIR_IDLE;
    end
    // RULE_05 active indication
    next_active = next_direction | next_ctrl[`CTL_START_EN] | next_ctrl[`CTL_RSTART_EN] |
                  next_ctrl[`CTL_STOP_EN] | next_ctrl[`CTL_RECV_EN] | next_ctrl[`CTL_ACK_EN];
  end

  // ==========================================================================
  // Read data
  always_comb begin
    status_word = 16'h0000;
    status_word[`BIT_BUF_FULL]    = buf_full;
    status_word[`BIT_UPDATE_ADDR] = update_addr;
    status_word[`BIT_DIRECTION]   = direction;
    status_word[`BIT_START]       = start_flag;
    status_word[`BIT_STOP]        = stop_flag;
    next_rdata = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `STATUS_ADDR:  next_rdata = status_word;
        `CONTROL_ADDR: next_rdata = ctrl;
        default:       next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl        <= `CTL_RESET_VALUE;
      buf_full    <= 1'b0;
      update_addr <= 1'b0;
      direction   <= 1'b0;
      start_flag  <= 1'b0;
      stop_flag   <= 1'b0;
      rdata       <= 16'h0000;
      active      <= 1'b0;
      dir_state   <= i2c_flags_pkg::DIR_IDLE;
    end else begin
      ctrl        <= next_ctrl;
      buf_full    <= next_buf_full;
      update_addr <= next_update_addr;
      direction   <= next_direction;
      start_flag  <= next_start_flag;
      stop_flag   <= next_stop_flag;
      rdata       <= next_rdata;
      active      <= next_active;
      dir_state   <= next_dir_state;
    end
  end

  assign reg_rdata_o        = rdata;
  assign buffer_full_flag_o = buf_full;
  assign port_active_o      = active;

  // ==========================================================================
  // Assertions
  a_bf_on_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_01
    (tx_load_i && port_en && next_ctrl[`CTL_PORT_EN]) |=> buffer_full_flag_o)
    else $error("buffer full not set after transmit load");
  a_bf_on_rx: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_02
    (rx_byte_i && next_ctrl[`CTL_PORT_EN]) |=> buf_full)
    else $error("buffer full not set after received byte");
  a_bf_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_02
    (buf_read_i && !rx_byte_i && !tx_load_i) |=> !buf_full)
    else $error("buffer full not cleared");
  a_dir_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_03
    (addr_match_i && next_ctrl[`CTL_PORT_EN] && !(dir_state == i2c_flags_pkg::DIR_VALID &&
     (start_det || stop_det || nack_i))) |=> (direction == $past(addr_rw_i)))
    else $error("direction not captured at address match");
  a_dir_window: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_03
    (dir_state == i2c_flags_pkg::DIR_VALID && (stop_det || nack_i)) |=> !direction)
    else $error("direction held past end of window");
  a_flags_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_04
    !port_en |-> (!start_flag && !stop_flag))
    else $error("start or stop flag set while disabled");
  a_active_or: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_05
    ##1 (port_active_o == (direction | (|ctrl[`CTL_ACK_EN:`CTL_START_EN]))))
    else $error("active indication mismatch");
  a_ua_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_06
    (ctrl[`CTL_TEN_BIT] && addr_high_done_i && next_ctrl[`CTL_PORT_EN]) |=> update_addr)
    else $error("update address request missing");
  a_stop_last: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_07
    (stop_det && !start_det && next_ctrl[`CTL_PORT_EN]) |=> (stop_flag && !start_flag))
    else $error("stop flag not reflecting last condition");
  a_start_last: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_07
    (start_det && next_ctrl[`CTL_PORT_EN]) |=> (start_flag && !stop_flag))
    else $error("start flag not reflecting last condition");
  a_bf_tx_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_01
    (tx_done_i && !tx_load_i && !rx_byte_i) |=> !buf_full)
    else $error("buffer full not cleared after transmit");
  a_dir_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_03
    (dir_state == i2c_flags_pkg::DIR_VALID && start_det) |=> !direction)
    else $error("direction held past start condition");
  a_ua_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_06
    (slave_addr_wr_i && !(ctrl[`CTL_TEN_BIT] && (addr_high_done_i || addr_match_i))) |=> !update_addr)
    else $error("update address request not cleared");
endmodule

/* verification/i2c_bus_model.sv */
// Behavioural far-side bus party that makes start and stop conditions.
`timescale 1ns/100ps
module i2c_bus_model (
  // Bus pins, driven idle high by the model
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ==========================================================
  // Conditions
  // start: data falls
  task automatic start_cond();
    #50 sda_o = 1'b0;
    #50 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #50 sda_o = 1'b0;
    #50 scl_o = 1'b1;
    #50 sda_o = 1'b1;
  endtask
endmodule

/* verification/test_i2c_port_status_flags.sv */
// Self-checking bench for the serial port status flags.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_i2c_port_status_flags;
  logic        ref_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        scl_i;
  logic        sda_i;
  logic [7:0]  ev          = 8'h00;
  logic        addr_rw_i   = 1'b0;
  logic        buffer_full_flag_o;
  logic        port_active_o;
  logic [15:0] rd_val;
  logic [15:0] ctl;
  logic        rw          = 1'b0;
  integer      seed        = 60;
  int          n_errors    = 0;
  int          tests_run   = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  i2c_bus_model bus_i (.scl_o(scl_i), .sda_o(sda_i));
  i2c_port_status_flags i2c_port_status_flags_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .sda_i(sda_i),
    .tx_load_i(ev[0]), .tx_done_i(ev[1]), .rx_byte_i(ev[2]), .buf_read_i(ev[3]), .addr_match_i(ev[4]),
    .addr_rw_i(addr_rw_i), .nack_i(ev[5]), .addr_high_done_i(ev[6]), .slave_addr_wr_i(ev[7]),
    .buffer_full_flag_o(buffer_full_flag_o), .port_active_o(port_active_o));
  // ==========================================================
  // Tasks
  function automatic logic [15:0] st(input logic bf, ua, dr, s, p);
    return {11'h000, p, s, dr, ua, bf};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  task automatic pulse_m(input logic [7:0] m);
    @(posedge ref_clk_i);
    ev <= m;
    addr_rw_i <= rw;
    @(posedge ref_clk_i);
    ev <= 8'h00;
    #1;
  endtask
  task automatic pulse(input int k);
    pulse_m(8'h01 << k);
  endtask
  task automatic settle();
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic conclude();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0); `CHK("status", 16'h0000, rd_val)
    @(posedge ref_clk_i);
    #1;
    `CHK("rdata idle", 16'h0000, reg_rdata_o)
    rd(4'h1); `CHK("control", 16'h0000, rd_val)
    wr(4'h0, 16'hFFFF); rd(4'h0); `CHK("status ro", 16'h0000, rd_val)
    wr(4'hF, 16'hFFFF); rd(4'hF); `CHK("unmapped", 16'h0000, rd_val)
    rd(4'h1); `CHK("control kept", 16'h0000, rd_val)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      ctl = (i == 0) ? 16'h0001 : (i == 1) ? 16'h007D : (16'h0001 | (16'($random(seed)) & 16'h007C));
      wr(4'h1, ctl);
      settle();
      `CHK("active", |ctl[6:2], port_active_o)
      rd(4'h1); `CHK("control", ctl, rd_val)
    end
    $display("test active done");
    wr(4'h1, 16'h0001);
    pulse(0); `CHK("bf tx", 1'b1, buffer_full_flag_o)
    settle(); `CHK("bf tx", 1'b1, buffer_full_flag_o)
    pulse(1); `CHK("bf tx", 1'b0, buffer_full_flag_o)
    pulse(2); `CHK("bf rx", 1'b1, buffer_full_flag_o)
    rd(4'h0); `CHK("status", st(1, 0, 0, 0, 0), rd_val)
    pulse(3); `CHK("bf rx", 1'b0, buffer_full_flag_o)
    pulse_m(8'h0C); `CHK("bf set wins", 1'b1, buffer_full_flag_o)
    pulse(3); `CHK("bf rx", 1'b0, buffer_full_flag_o)
    $display("test buffer done");
    for (int i = 0; i < 4; i++) begin
      rw = (i == 0) ? 1'b1 : 1'($random(seed));
      pulse(4);
      rd(4'h0); `CHK("direction", st(0, 0, rw, 0, 0), rd_val)
      settle(); `CHK("active", rw, port_active_o)
      pulse(5);
      rd(4'h0); `CHK("direction", 16'h0000, rd_val)
    end
    $display("test direction done");
    wr(4'h1, 16'h0003);
    pulse(6); rd(4'h0); `CHK("update", st(0, 1, 0, 0, 0), rd_val)
    pulse(7); rd(4'h0); `CHK("update", 16'h0000, rd_val)
    rw = 1'b1;
    pulse(4); rd(4'h0); `CHK("update match", st(0, 1, 1, 0, 0), rd_val)
    pulse_m(8'hE0); rd(4'h0); `CHK("update set wins", st(0, 1, 0, 0, 0), rd_val)
    pulse(7); rd(4'h0); `CHK("update", 16'h0000, rd_val)
    wr(4'h1, 16'h0001);
    $display("test update done");
    rw = 1'b1;
    pulse(4);
    bus_i.start_cond();
    settle(); rd(4'h0); `CHK("start", st(0, 0, 0, 1, 0), rd_val)
    bus_i.stop_cond();
    settle(); rd(4'h0); `CHK("stop", st(0, 0, 0, 0, 1), rd_val)
    wr(4'h1, 16'h0000); rd(4'h0); `CHK("disable", 16'h0000, rd_val)
    wr(4'h1, 16'h0001);
    bus_i.start_cond();
    settle(); rd(4'h0); `CHK("start again", st(0, 0, 0, 1, 0), rd_val)
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0); `CHK("status reset", 16'h0000, rd_val)
    rd(4'h1); `CHK("control reset", 16'h0000, rd_val)
    $display("test conditions done");
    conclude();
  end
endmodule
